/* pkg/qadc_pkg.sv */
// Constants, state type and helpers shared by the quad converter serial output block
package qadc_pkg;

  // ***************************************************************
  // Geometry
  // ***************************************************************
  localparam int NUM_LANES      = 4;
  localparam int SAMPLE_W       = 8;
  localparam int AXI_ADDR_W     = 4;
  localparam int FRAME_HALF     = 4;   // Bit slots with frame clock high

  // ***************************************************************
  // Register map (byte addresses)
  // ***************************************************************
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_STATUS = 4'h4;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK   = 32'h0000_1FFF;

  // Control fields
  localparam int CTRL_CHAN_PD_LSB = 0;   // Four bits, one per lane
  localparam int CTRL_STANDBY     = 4;
  localparam int CTRL_LOW_SWING   = 5;
  localparam int CTRL_DRIVE_BOOST = 6;
  localparam int CTRL_TWOS_COMP   = 7;
  localparam int CTRL_LSB_FIRST   = 8;
  localparam int CTRL_LOW_RATE    = 9;
  localparam int CTRL_PHASE_LSB   = 10;  // Three bits, 0 = 90 deg, +60 deg per step

  // Status fields
  localparam int STAT_PDOWN     = 0;
  localparam int STAT_STANDBY   = 1;
  localparam int STAT_RUN       = 2;
  localparam int STAT_SETTLED   = 3;
  localparam int STAT_STRAP     = 4;
  localparam int STAT_FIFO_LSB  = 8;     // Two bits of buffer fill level

  // ***************************************************************
  // Coding and bus answers
  // ***************************************************************
  localparam logic [7:0] MIDSCALE    = 8'h80;
  localparam logic [7:0] TWOS_FLIP   = 8'h80;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int STBY_WAKE_NS  = 600;
  localparam int SETTLE_US     = 375;
  localparam int WAKE_CYC      = (STBY_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC    = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {QS_PDOWN, QS_RUN, QS_STBY, QS_WAKE} qadc_state_t;

  // Serial slot to sample bit position, honouring the bit order option
  function automatic logic [2:0] qadc_bit_pos(input logic [2:0] slot, input logic lsb_first);
    qadc_bit_pos = lsb_first ? slot : 3'h7 - slot;
  endfunction

endpackage

/* hw/qadc_serial_out.sv */
// Serial output, power-down and mode control of a four-lane 8-bit sampling converter
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Power-down pin high puts the device in power-down and stops all conversion.
// - In power-down all lane, bit clock and frame clock drivers float.
// - Power-down pin low returns to standby if its register bit is set, else to normal mode and restarts conversion and output.
// - Pin power-down turns off reference, reference buffer, PLL and bias.
// - Registers give per-lane power-down and standby keeping PLL on, 600 ns wake.
// - Outputs start at standard swing; strap or register picks reduced swing.
// - Register option raises termination and drive current on all data lanes.
// - Coding is offset binary by default; register selects twos complement.
// - Offset binary: full scale all ones, zero 1000 0000, minus full scale zeros.
// - Each channel has its own lane at eight bits per sample period.
// - Lowest rate 10 MSPS normally; register option lets PLL accept 5 MSPS.
// - Bit clock runs at four times sample rate, data launched on both edges.
// - Frame clock runs at sample rate, its rising edge marks each new byte.
// - Most significant bit first by default; register option sends least first.
// - Bit clock phase defaults to 90 degrees, adjustable in 60 degree steps.
module qadc_serial_out
  import qadc_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Pins
  input  wire logic                      power_down_pin,
  input  wire logic                      output_mode_strap,
  input  wire logic                      sample_clock,
  // Samples from the converter core, lane c in bits [8c+7:8c]
  input  wire logic [NUM_LANES*8-1:0]    smp_data,
  input  wire logic                      smp_valid,
  output logic                           smp_ready,
  // Serial lanes and clocks, enables low while driving
  output logic [NUM_LANES-1:0]           lane_out,
  output logic [NUM_LANES-1:0]           lane_oe_n,
  output logic                           bit_clock_out,
  output logic                           bit_clock_oe_n,
  output logic                           frame_clock_out,
  output logic                           frame_clock_oe_n,
  // Analog and driver controls
  output logic                           conv_en,
  output logic                           ref_en,
  output logic                           pll_en,
  output logic                           bias_en,
  output logic                           pll_low_rate,
  output logic                           low_swing,
  output logic                           drive_boost,
  output logic [2:0]                     bit_clock_phase,
  // AXI4-Lite slave
  input  wire logic [AXI_ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  qadc_state_t                 state_q, state_d;
  logic [2:0]                  pd_sync_q, sclk_sync_q;
  logic [1:0]                  strap_sync_q;
  logic                        strap_q;
  logic [1:0]                  strap_taken_q;
  logic [31:0]                 ctrl_q;
  logic [3:0]                  wake_cnt_q;
  logic [11:0]                 settle_cnt_q;
  logic                        settled_q;
  logic [NUM_LANES*8-1:0]      fifo_mem [2];
  logic                        wr_ptr_q, rd_ptr_q;
  logic [1:0]                  cnt_q, cnt_d;
  logic [NUM_LANES-1:0][7:0]   word_q, head_word, word_src;
  logic [2:0]                  idx_q, idx_d;
  logic                        pd_req, stby_req, sclk_rise, frame_go, push, pop;
  logic [AXI_ADDR_W-1:0]       aw_addr_q;
  logic [31:0]                 w_data_q;
  logic [3:0]                  w_strb_q;
  logic                        aw_full_q, w_full_q;

  assign pd_req    = pd_sync_q[1];
  assign stby_req  = ctrl_q[CTRL_STANDBY];
  assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
  assign frame_go  = (state_q == QS_RUN) && sclk_rise;

  // ***************************************************************
  // Pin synchronisers and strap capture
  // ***************************************************************
  // Power-down pin and sample clock come from outside the clk domain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pd_sync_q   <= 3'h0;
      sclk_sync_q <= 3'h0;
    end else begin
      pd_sync_q   <= {pd_sync_q[1:0], power_down_pin};
      sclk_sync_q <= {sclk_sync_q[1:0], sample_clock};
    end
  end

  // Strap caught at third edge after release, once the sync holds the pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_sync_q  <= 2'h0;
      strap_q       <= 1'b0;
      strap_taken_q <= 2'h0;
    end else begin
      strap_sync_q <= {strap_sync_q[0], output_mode_strap};
      if (strap_taken_q != 2'h3) begin
        strap_q       <= strap_sync_q[1];
        strap_taken_q <= strap_taken_q + 2'h1;
      end
    end
  end

  // ***************************************************************
  // Power state machine
  // ***************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      QS_PDOWN: if (!pd_req) state_d = stby_req ? QS_STBY : QS_RUN;
      QS_RUN:   if (pd_req) state_d = QS_PDOWN;
                else if (stby_req) state_d = QS_STBY;
      QS_STBY:  if (pd_req) state_d = QS_PDOWN;
                else if (!stby_req) state_d = QS_WAKE;
      QS_WAKE:  if (pd_req) state_d = QS_PDOWN;
                else if (stby_req) state_d = QS_STBY;
                else if (wake_cnt_q == 4'(WAKE_CYC - 1)) state_d = QS_RUN;
      default:  state_d = QS_PDOWN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) state_q <= QS_PDOWN;
    else        state_q <= state_d;
  end

  // Standby wake delay, PLL stays up so only a short wait
  always_ff @(posedge clk) begin
    if (!rst_n || state_q != QS_WAKE) wake_cnt_q <= 4'h0;
    else                              wake_cnt_q <= wake_cnt_q + 4'h1;
  end

  // Settling time after full power-down, reported for the receiver's benefit
  always_ff @(posedge clk) begin
    if (!rst_n || state_q == QS_PDOWN) begin
      settle_cnt_q <= 12'h000;
      settled_q    <= 1'b0;
    end else if (settle_cnt_q == 12'(SETTLE_CYC - 1)) begin
      settled_q    <= 1'b1;
    end else begin
      settle_cnt_q <= settle_cnt_q + 12'h001;
    end
  end

  // Analog enables and pin drivers, all from the next state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conv_en          <= 1'b0;
      ref_en           <= 1'b0;
      pll_en           <= 1'b0;
      bias_en          <= 1'b0;
      lane_oe_n        <= '1;
      bit_clock_oe_n   <= 1'b1;
      frame_clock_oe_n <= 1'b1;
    end else begin
      conv_en          <= (state_d == QS_RUN);
      ref_en           <= (state_d != QS_PDOWN);
      pll_en           <= (state_d != QS_PDOWN);
      bias_en          <= (state_d != QS_PDOWN);
      lane_oe_n        <= {NUM_LANES{state_d == QS_PDOWN}};
      bit_clock_oe_n   <= (state_d == QS_PDOWN);
      frame_clock_oe_n <= (state_d == QS_PDOWN);
    end
  end

  // Mode pins follow the control register; reduced swing also by strap
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_swing       <= 1'b0;
      drive_boost     <= 1'b0;
      pll_low_rate    <= 1'b0;
      bit_clock_phase <= 3'h0;
    end else begin
      low_swing       <= strap_q | ctrl_q[CTRL_LOW_SWING];
      drive_boost     <= ctrl_q[CTRL_DRIVE_BOOST];
      pll_low_rate    <= ctrl_q[CTRL_LOW_RATE];
      bit_clock_phase <= ctrl_q[CTRL_PHASE_LSB +: 3];
    end
  end

  // ***************************************************************
  // Two-entry sample buffer
  // ***************************************************************
  assign push  = smp_valid && smp_ready;
  assign pop   = frame_go && (cnt_q != 2'h0);
  assign cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_q  <= 1'b0;
      rd_ptr_q  <= 1'b0;
      cnt_q     <= 2'h0;
      smp_ready <= 1'b0;
    end else begin
      if (push) begin
        fifo_mem[wr_ptr_q] <= smp_data;
        wr_ptr_q           <= ~wr_ptr_q;
      end
      if (pop) rd_ptr_q <= ~rd_ptr_q;
      cnt_q     <= cnt_d;
      smp_ready <= (cnt_d != 2'h2);    // Stall source while both slots hold words
    end
  end

  // ***************************************************************
  // Serializer
  // ***************************************************************
  // Empty buffer repeats midscale rather than stale data
  always_comb begin
    for (int c = 0; c < NUM_LANES; c++) begin
      head_word[c] = (cnt_q != 2'h0) ? fifo_mem[rd_ptr_q][c*8 +: 8] : MIDSCALE;
      if (ctrl_q[CTRL_TWOS_COMP]) head_word[c] = head_word[c] ^ TWOS_FLIP;
    end
  end

  assign word_src = frame_go ? head_word : word_q;

  // Slot counter parks on the last slot until the next sample clock rise
  always_comb begin
    if (state_q != QS_RUN)      idx_d = 3'h7;
    else if (frame_go)          idx_d = 3'h0;
    else if (idx_q == 3'h7)     idx_d = 3'h7;
    else                        idx_d = idx_q + 3'h1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idx_q  <= 3'h7;
      word_q <= '0;
    end else begin
      idx_q  <= idx_d;
      word_q <= word_src;
    end
  end

  // One bit per clk on every lane; bit clock toggles each bit for DDR
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lane_out        <= '0;
      bit_clock_out   <= 1'b0;
      frame_clock_out <= 1'b0;
    end else begin
      for (int c = 0; c < NUM_LANES; c++) begin
        lane_out[c] <= (state_d == QS_RUN) && !ctrl_q[CTRL_CHAN_PD_LSB + c]
                       && word_src[c][qadc_bit_pos(idx_d, ctrl_q[CTRL_LSB_FIRST])];
      end
      if (state_d != QS_RUN)  bit_clock_out <= 1'b0;
      else if (frame_go)      bit_clock_out <= 1'b1;
      else                    bit_clock_out <= ~bit_clock_out;
      frame_clock_out <= (state_d == QS_RUN) && (idx_d < 3'(FRAME_HALF));
    end
  end

  // ***************************************************************
  // AXI4-Lite register access
  // ***************************************************************
  // Address and data taken independently, then written together
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      ctrl_q        <= CTRL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        aw_full_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        w_full_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_full_q && w_full_q && !s_axi_bvalid) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_q == ADDR_CTRL) begin
          for (int b = 0; b < 4; b++) begin
            if (w_strb_q[b]) ctrl_q[b*8 +: 8] <= w_data_q[b*8 +: 8] & CTRL_MASK[b*8 +: 8];
          end
          s_axi_bresp <= RESP_OKAY;
        end else if (aw_addr_q == ADDR_STATUS) begin
          s_axi_bresp <= RESP_OKAY;     // Status is read only, write ignored
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read answers one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= RESP_OKAY;
        s_axi_rdata   <= 32'h0000_0000;
        if (s_axi_araddr == ADDR_CTRL) begin
          s_axi_rdata <= ctrl_q;
        end else if (s_axi_araddr == ADDR_STATUS) begin
          s_axi_rdata[STAT_PDOWN]           <= (state_q == QS_PDOWN);
          s_axi_rdata[STAT_STANDBY]         <= (state_q == QS_STBY);
          s_axi_rdata[STAT_RUN]             <= (state_q == QS_RUN);
          s_axi_rdata[STAT_SETTLED]         <= settled_q;
          s_axi_rdata[STAT_STRAP]           <= strap_q;
          s_axi_rdata[STAT_FIFO_LSB +: 2]   <= cnt_q;
        end else begin
          s_axi_rresp <= RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_pd_float:     assert property (pd_req |-> ##1 (&lane_oe_n && bit_clock_oe_n && frame_clock_oe_n))
    else $error("drivers not floating in power-down");
  chk_pd_stop:      assert property (pd_req |-> ##1 (!conv_en && lane_out == '0))
    else $error("conversion still running in power-down");
  chk_pd_analog:    assert property (state_q == QS_PDOWN |-> (!ref_en && !pll_en && !bias_en))
    else $error("analog blocks on in power-down");
  chk_pd_resume:    assert property ($fell(pd_req) && !stby_req |-> ##1 state_q == QS_RUN)
    else $error("no resume after power-down release");
  chk_stby_pll:     assert property (state_q == QS_STBY |-> pll_en && !conv_en)
    else $error("standby lost the PLL");
  chk_stby_wake:    assert property ((state_q == QS_STBY && !stby_req && !pd_req) |-> ##[2:8] state_q == QS_RUN)
    else $error("standby wake too slow");
  chk_lane_bits:    assert property ((state_q == QS_RUN && $stable(ctrl_q) && !ctrl_q[CTRL_CHAN_PD_LSB])
                      |-> lane_out[0] == word_q[0][qadc_bit_pos(idx_q, ctrl_q[CTRL_LSB_FIRST])])
    else $error("lane bit out of order");
  chk_lane_quiet:   assert property ((ctrl_q[CTRL_CHAN_PD_LSB + 1] && $past(ctrl_q[CTRL_CHAN_PD_LSB + 1])) |-> !lane_out[1])
    else $error("powered-down lane toggles");
  chk_frame_align:  assert property (frame_go && state_d == QS_RUN |=> frame_clock_out && idx_q == 3'h0 && bit_clock_out)
    else $error("frame start misaligned");
  chk_frame_len:    assert property ($rose(frame_clock_out) && state_q == QS_RUN && !sclk_rise
                      |-> (frame_clock_out || state_q != QS_RUN)[*4] ##1 !frame_clock_out)
    else $error("frame clock high length wrong");
  chk_bitclk_ddr:   assert property ((state_q == QS_RUN && state_d == QS_RUN && !frame_go) |=> bit_clock_out != $past(bit_clock_out))
    else $error("bit clock missed a toggle");
  chk_coding:       assert property (frame_go && state_d == QS_RUN && cnt_q != 2'h0
                      |=> word_q[0] == ($past(fifo_mem[rd_ptr_q][7:0])
                          ^ ($past(ctrl_q[CTRL_TWOS_COMP]) ? TWOS_FLIP : 8'h00)))
    else $error("sample coding lost");

  cov_frame:        cover property (frame_go ##8 frame_go);
  cov_pd_cycle:     cover property ($rose(pd_req) ##[1:50] $fell(pd_req));
  cov_stby_wake:    cover property (state_q == QS_WAKE ##[1:8] state_q == QS_RUN);
  cov_buf_full:     cover property (cnt_q == 2'h2 && !smp_ready);

endmodule

`default_nettype wire

/* test/qadc_rx_model.sv */
// Behavioural receiver that deserialises the four lanes against the frame clock
`timescale 1ns/1ps
`default_nettype none
module qadc_rx_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  lane_out,
  input  wire logic [3:0]  lane_oe_n,
  input  wire logic        bit_clock_out,
  input  wire logic        frame_clock_out,
  input  wire logic        frame_clock_oe_n,
  output logic      [31:0] rx_word,
  output logic             rx_stb
);
  logic       fco_q;
  logic       dco_q;
  logic [3:0] cnt;
  // Floated lane reads as inverse of lane_out, which is held low in power-down, so it reads high
  wire logic [3:0] ln = lane_out ^ lane_oe_n;
  wire logic       start = frame_clock_out && !fco_q;
  // One bit per bit clock edge, rise or fall; byte opens at frame rise
  always @(posedge clk) begin
    fco_q <= frame_clock_out;
    dco_q <= bit_clock_out;
    rx_stb <= 1'b0;
    if (!rst_n || frame_clock_oe_n) begin
      cnt <= 4'h8;
    end else if (start || (cnt < 4'h8 && bit_clock_out != dco_q)) begin
      cnt <= start ? 4'h1 : cnt + 4'h1;
      rx_stb <= (cnt == 4'h7) && !start;
      for (int c = 0; c < 4; c++) rx_word[8*c +: 8] <= {rx_word[8*c +: 7], ln[c]};
    end
  end
endmodule
`default_nettype wire

/* test/quad_adc_serial_output_and_powerdown_tb_top.sv */
// Self-checking bench for the quad converter serial output block
`timescale 1ns/1ps
`default_nettype none
module quad_adc_serial_output_and_powerdown_tb_top;
  import qadc_pkg::*;
  logic        clk, rst_n, power_down_pin, output_mode_strap, sample_clock;
  logic        smp_valid, smp_ready, rx_stb, bit_clock_out, bit_clock_oe_n;
  logic        frame_clock_out, frame_clock_oe_n, conv_en, ref_en, pll_en, bias_en;
  logic        pll_low_rate, low_swing, drive_boost;
  logic [2:0]  bit_clock_phase;
  logic [31:0] smp_data, s_axi_wdata, s_axi_rdata, rx_word, ctrl_m, rd, e;
  logic [3:0]  lane_out, lane_oe_n, s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  int          n_mismatch, samples_checked, cyc, skip_until;
  logic [31:0] q[$];
  logic [31:0] tab[5] = '{32'h0000_0080, 32'h0000_0105, 32'h0000_166A, 32'h0000_0180, 32'h0};
  qadc_serial_out i_dut (.*);
  qadc_rx_model i_rx (.*);
  // ************************************************************
  // Tasks and reference model
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Write offers address and data together, each dropped once taken
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk(s_axi_bresp, RESP_OKAY);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Expected lane bytes as the receiver assembles them, first bit on top
  function automatic logic [31:0] xf(input logic [31:0] s);
    logic [7:0] b;
    for (int c = 0; c < NUM_LANES; c++) begin
      b = s[8*c +: 8] ^ (ctrl_m[CTRL_TWOS_COMP] ? TWOS_FLIP : 8'h00);
      if (ctrl_m[CTRL_LSB_FIRST]) b = {<<{b}};
      xf[8*c +: 8] = ctrl_m[CTRL_CHAN_PD_LSB + c] ? 8'h00 : b;
    end
  endfunction
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Sample clock free-running, phase unrelated to clk
  initial begin
    sample_clock = 1'b0;
    #3030;
    forever #400 sample_clock = ~sample_clock;
  end
  // Push accepted words; match each received byte set, stale entries dropped
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
    if (smp_valid && smp_ready) begin
      q.push_back(smp_data);
      smp_data <= $urandom;
    end
    if (rx_stb && cyc > skip_until) begin
      e = 32'h0;
      while (q.size() > 0) begin
        e = xf(q.pop_front());
        if (e === rx_word) break;
      end
      chk(rx_word, e);
    end
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    void'($urandom(32'hB4E5));
    {n_mismatch, samples_checked, cyc, skip_until} = '0;
    {rst_n, power_down_pin, output_mode_strap, smp_valid} = 4'h0;
    smp_data = 32'hFF80_007F;
    ctrl_m = CTRL_RST;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    smp_valid <= 1'b1;
    axr(ADDR_CTRL, rd, rr);
    chk(rd, CTRL_RST);
    chk({low_swing, drive_boost, pll_low_rate}, 32'h0);
    axr(4'h8, rd, rr);
    chk(rr, RESP_SLVERR);
    repeat (200) @(posedge clk);
    foreach (tab[i]) begin
      axw(ADDR_CTRL, tab[i]);
      ctrl_m = tab[i];
      skip_until = cyc + 30;
      axr(ADDR_CTRL, rd, rr);
      chk(rd, tab[i] & CTRL_MASK);
      chk({bit_clock_phase, pll_low_rate, drive_boost, low_swing}, {tab[i][12:9], tab[i][6:5]});
      repeat (100) @(posedge clk);
    end
    // Standby keeps the PLL on and wakes within the short count; cut frames skipped
    skip_until = cyc + 60;
    axw(ADDR_CTRL, 32'h0000_0010);
    repeat (4) @(posedge clk);
    chk({conv_en, pll_en, lane_out}, 6'h10);
    axw(ADDR_CTRL, 32'h0);
    repeat (WAKE_CYC + 3) @(posedge clk);
    chk(conv_en, 32'h1);
    skip_until = cyc + 30;
    power_down_pin <= 1'b1;
    repeat (6) @(posedge clk);
    chk({lane_oe_n, bit_clock_oe_n, frame_clock_oe_n, conv_en, ref_en, pll_en, bias_en}, 10'h3F0);
    axr(ADDR_STATUS, rd, rr);
    chk(rd & 32'h7, 32'h1);
    power_down_pin <= 1'b0;
    skip_until = cyc + SETTLE_CYC;
    repeat (SETTLE_CYC + 100) @(posedge clk);
    chk({lane_oe_n, conv_en}, 5'h01);
    axr(ADDR_STATUS, rd, rr);
    chk(rd & 32'hF, 32'hC);
    report_and_stop();
  end
endmodule
`default_nettype wire
